// ==== core/lcpsc_defines.vh ====
// Function
// - Victim found by walking seven-bit tree
// - Flash invalidate clears tree to way zero
// - Non-snoop, non-inhibited access marks way most recent
// - Hit or reload updates exactly three bits
// - Fixed update values per way
// - Vector LRU hit writes complemented values; dcache only
// - Vector LRU miss inverts at reload; dcache only
// - Victim ignores valid bits
// - Data victim at reload, instruction at miss
// - Flash invalidate drops whole cache, no writeback
// - Requests carry access attributes unchanged, except castouts, which set or clear write-through
// - Cacheable load miss deallocates and reloads; write-through miss only requests, no reload
// - Load hit returns data, no request
// - Critical portion forwarded before line
// - Stores update cache/memory, never forward
// - Touch miss reloads unless inhibited or write-through, never forwards
// - Stream stop halts stream, no request
// - Reserve sets reservation; conditional needs it
// - Allocation casts out modified victim
// - Block zero owns line, zeroes, modified; inhibited or write-through just completes
// - Block store/flush writes out, invalidates
`ifndef LCPSC_DEFINES_VH
`define LCPSC_DEFINES_VH
`define LCPSC_SETS        128
`define LCPSC_SET_W       7
`define LCPSC_WAYS        8
`define LCPSC_WAY_W       3
`define LCPSC_TREE_W      7
`define LCPSC_TREE_RST    7'h00
// Line states
`define LCPSC_ST_I        2'h0
`define LCPSC_ST_S        2'h1
`define LCPSC_ST_E        2'h2
`define LCPSC_ST_M        2'h3
// Attribute bit positions: write-through, inhibit, coherence
`define LCPSC_ATTR_W      2
`define LCPSC_ATTR_I      1
`define LCPSC_ATTR_M      0
// Operation codes from the load/store unit
`define LCPSC_OP_LOAD     4'h0
`define LCPSC_OP_STORE    4'h1
`define LCPSC_OP_TOUCH    4'h2
`define LCPSC_OP_TOUCHST  4'h3
`define LCPSC_OP_STOP     4'h4
`define LCPSC_OP_LDRES    4'h5
`define LCPSC_OP_STCOND   4'h6
`define LCPSC_OP_BSTORE   4'h7
`define LCPSC_OP_BFLUSH   4'h8
`define LCPSC_OP_BZERO    4'h9
`define LCPSC_OP_FETCH    4'ha
// Memory subsystem request codes
`define LCPSC_RQ_NONE     4'h0
`define LCPSC_RQ_LOAD     4'h1
`define LCPSC_RQ_STORE    4'h2
`define LCPSC_RQ_TOUCH    4'h3
`define LCPSC_RQ_STOUCH   4'h4
`define LCPSC_RQ_RESLOAD  4'h5
`define LCPSC_RQ_STCOND   4'h6
`define LCPSC_RQ_BSTORE   4'h7
`define LCPSC_RQ_BFLUSH   4'h8
`define LCPSC_RQ_CLEAN    4'h9
`define LCPSC_RQ_CASTOUT  4'ha
`define LCPSC_RQ_BZERO    4'hb
`define LCPSC_RQ_FETCH    4'hc
`endif

// ==== core/lcpsc_tree.v ====
`timescale 1ns/100ps
`default_nettype none
`include "lcpsc_defines.vh"
// Per-set pseudo LRU tree store for one cache
module lcpsc_tree (
  input  wire       clock,
  input  wire       srst,
  input  wire       clear,
  input  wire [6:0] rd_set,
  output wire [2:0] victim,
  input  wire       upd,
  input  wire [6:0] upd_set,
  input  wire [2:0] upd_way,
  input  wire       upd_inv
);
  reg [6:0] tree [0:127];
  reg       tree_ok [0:127];
  integer   k;
  wire [6:0] cur = tree_ok[rd_set] ? tree[rd_set] : `LCPSC_TREE_RST;
  wire [6:0] old = tree_ok[upd_set] ? tree[upd_set] : `LCPSC_TREE_RST;

  // Tree walk, root then side then leaf; valid bits not consulted
  function [2:0] walk;
    input [6:0] t;
    begin
      if (!t[0])
        walk = t[1] ? {2'b01, t[4]} : {2'b00, t[3]};
      else
        walk = t[2] ? {2'b11, t[6]} : {2'b10, t[5]};
    end
  endfunction

  // Rewrite three bits on the path to a way, optionally inverted
  function [6:0] touch;
    input [6:0] t;
    input [2:0] w;
    input       inv;
    reg   [6:0] n;
    begin
      n = t;
      n[0] = ~w[2] ^ inv;
      if (!w[2]) begin
        n[1] = ~w[1] ^ inv;
        if (!w[1]) n[3] = ~w[0] ^ inv;
        else n[4] = ~w[0] ^ inv;
      end else begin
        n[2] = ~w[1] ^ inv;
        if (!w[1]) n[5] = ~w[0] ^ inv;
        else n[6] = ~w[0] ^ inv;
      end
      touch = n;
    end
  endfunction

  assign victim = walk(cur);

  // Valid flags make a one-cycle clear of every set possible
  always @(posedge clock) begin
    if (srst || clear) begin
      for (k = 0; k < 128; k = k + 1)
        tree_ok[k] <= 1'b0;
    end else if (upd) begin
      tree[upd_set]    <= touch(old, upd_way, upd_inv);
      tree_ok[upd_set] <= 1'b1;
    end
  end
endmodule // lcpsc_tree
`default_nettype wire

// ==== core/lcpsc_state.v ====
`timescale 1ns/100ps
`default_nettype none
`include "lcpsc_defines.vh"
// Line state array with single-cycle flash invalidate
module lcpsc_state (
  input  wire       clock,
  input  wire       srst,
  input  wire       flash,
  input  wire [9:0] rd_idx,
  output wire [1:0] rd_state,
  input  wire       wr,
  input  wire [9:0] wr_idx,
  input  wire [1:0] wr_state
);
  reg [1:0] st [0:1023];
  reg       ok [0:1023];
  integer   k;
  assign rd_state = ok[rd_idx] ? st[rd_idx] : `LCPSC_ST_I;

  // Flash drops every line without writeback
  always @(posedge clock) begin
    if (srst || flash) begin
      for (k = 0; k < 1024; k = k + 1)
        ok[k] <= 1'b0;
    end else if (wr) begin
      st[wr_idx] <= wr_state;
      ok[wr_idx] <= 1'b1;
    end
  end
endmodule // lcpsc_state
`default_nettype wire

// ==== core/lcpsc_ctrl.v ====
`timescale 1ns/100ps
`default_nettype none
`include "lcpsc_defines.vh"
// L1 line state, replacement and memory subsystem request control
module lcpsc_ctrl (
  input  wire        clock,
  input  wire        srst,
  input  wire        data_flash_invalidate_bit,
  input  wire        instr_flash_invalidate_bit,
  input  wire        req_valid,
  input  wire [3:0]  req_op,
  input  wire [6:0]  req_set,
  input  wire [2:0]  req_way,
  input  wire        req_hit,
  input  wire        req_vlru,
  input  wire        req_snoop,
  input  wire [2:0]  access_attribute_bits,
  input  wire [3:0]  req_stream,
  input  wire        rsp_valid,
  input  wire        rsp_excl,
  input  wire        rsp_crit,
  input  wire        rsp_last,
  output reg         busy,
  output reg         mss_valid,
  output reg  [3:0]  mss_req,
  output reg  [2:0]  mss_attr,
  output reg  [6:0]  mss_set,
  output reg  [2:0]  mss_way,
  output reg         fwd_crit,
  output reg         fwd_hit,
  output reg         done,
  output reg         reservation,
  output reg         stcond_ok,
  output reg  [15:0] stream_active,
  output reg         zero_line,
  output reg  [2:0]  ic_victim,
  output reg  [1:0]  line_state
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_CAST = 2'h2;

  reg  [1:0] state;
  reg  [3:0] op;
  reg  [6:0] set;
  reg        vlru;
  reg        fetch;
  reg  [2:0] attr;
  reg        got_excl;
  reg        d_upd;
  reg  [6:0] d_upd_set;
  reg  [2:0] d_upd_way;
  reg        d_upd_inv;
  reg        i_upd;
  reg  [6:0] i_upd_set;
  reg  [2:0] i_upd_way;
  reg        s_wr;
  reg  [9:0] s_idx;
  reg  [1:0] s_val;
  wire [2:0] d_victim;
  wire [2:0] i_victim;
  wire [1:0] cur_st;
  wire [1:0] vic_st;
  wire       inh = access_attribute_bits[`LCPSC_ATTR_I];
  wire       wt  = access_attribute_bits[`LCPSC_ATTR_W];
  wire       coh = access_attribute_bits[`LCPSC_ATTR_M];
  wire       is_fetch = (req_op == `LCPSC_OP_FETCH);
  wire [9:0] cur_idx = {req_set, req_way};
  wire [9:0] vic_idx = {set, d_victim};

  lcpsc_tree u_dtree (
    .clock   (clock),
    .srst    (srst),
    .clear   (data_flash_invalidate_bit),
    .rd_set  (set),
    .victim  (d_victim),
    .upd     (d_upd),
    .upd_set (d_upd_set),
    .upd_way (d_upd_way),
    .upd_inv (d_upd_inv)
  );

  lcpsc_tree u_itree (
    .clock   (clock),
    .srst    (srst),
    .clear   (instr_flash_invalidate_bit),
    .rd_set  (req_set),
    .victim  (i_victim),
    .upd     (i_upd),
    .upd_set (i_upd_set),
    .upd_way (i_upd_way),
    .upd_inv (1'b0)
  );

  lcpsc_state u_dstate (
    .clock    (clock),
    .srst     (srst),
    .flash    (data_flash_invalidate_bit),
    .rd_idx   ((state == ST_IDLE) ? cur_idx : vic_idx),
    .rd_state (cur_st),
    .wr       (s_wr),
    .wr_idx   (s_idx),
    .wr_state (s_val)
  );
  assign vic_st = cur_st;

  // Main sequencer: one operation in flight at a time
  always @(posedge clock) begin
    if (srst) begin
      state         <= ST_IDLE;
      busy          <= 1'b0;
      mss_valid     <= 1'b0;
      mss_req       <= `LCPSC_RQ_NONE;
      mss_attr      <= 3'h0;
      mss_set       <= 7'h00;
      mss_way       <= 3'h0;
      fwd_crit      <= 1'b0;
      fwd_hit       <= 1'b0;
      done          <= 1'b0;
      reservation   <= 1'b0;
      stcond_ok     <= 1'b0;
      stream_active <= 16'h0000;
      zero_line     <= 1'b0;
      ic_victim     <= 3'h0;
      line_state    <= `LCPSC_ST_I;
      op            <= 4'h0;
      set           <= 7'h00;
      vlru          <= 1'b0;
      fetch         <= 1'b0;
      attr          <= 3'h0;
      got_excl      <= 1'b0;
      d_upd         <= 1'b0;
      d_upd_set     <= 7'h00;
      d_upd_way     <= 3'h0;
      d_upd_inv     <= 1'b0;
      i_upd         <= 1'b0;
      i_upd_set     <= 7'h00;
      i_upd_way     <= 3'h0;
      s_wr          <= 1'b0;
      s_idx         <= 10'h000;
      s_val         <= `LCPSC_ST_I;
    end else begin
      mss_valid <= 1'b0;
      fwd_crit  <= 1'b0;
      fwd_hit   <= 1'b0;
      done      <= 1'b0;
      zero_line <= 1'b0;
      d_upd     <= 1'b0;
      i_upd     <= 1'b0;
      s_wr      <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (req_valid) begin
            op        <= req_op;
            set       <= req_set;
            vlru      <= req_vlru && !is_fetch;
            fetch     <= is_fetch;
            attr      <= access_attribute_bits;
            mss_attr  <= access_attribute_bits;
            mss_set   <= req_set;
            mss_way   <= req_way;
            line_state <= cur_st;
            // Non-inhibited hits mark the way most recent, or least recent under vector LRU for data hits; snoops leave the tree
            if (req_hit && !req_snoop && !inh) begin
              if (is_fetch) begin
                i_upd     <= 1'b1;
                i_upd_set <= req_set;
                i_upd_way <= req_way;
              end else begin
                d_upd     <= 1'b1;
                d_upd_set <= req_set;
                d_upd_way <= req_way;
                d_upd_inv <= req_vlru;
              end
            end
            case (req_op)
              `LCPSC_OP_FETCH: begin
                if (req_hit) begin
                  fwd_hit <= 1'b1;
                  done    <= 1'b1;
                end else begin
                  ic_victim <= i_victim;
                  mss_way   <= i_victim;
                  mss_req   <= `LCPSC_RQ_FETCH;
                  mss_valid <= 1'b1;
                  state     <= ST_WAIT;
                  busy      <= 1'b1;
                end
              end
              `LCPSC_OP_LOAD, `LCPSC_OP_LDRES, `LCPSC_OP_TOUCH, `LCPSC_OP_TOUCHST: begin
                if (req_op == `LCPSC_OP_LDRES)
                  reservation <= 1'b1;
                if (inh) begin
                  // Inhibited: a plain load passes through, other ops just complete; no line touched
                  if (req_op == `LCPSC_OP_LOAD) begin
                    mss_req   <= `LCPSC_RQ_LOAD;
                    mss_valid <= 1'b1;
                    state     <= ST_WAIT;
                    busy      <= 1'b1;
                  end else
                    done <= 1'b1;
                end else if (req_hit && !(req_op == `LCPSC_OP_TOUCHST
                                         && cur_st == `LCPSC_ST_S)) begin
                  fwd_hit <= (req_op == `LCPSC_OP_LOAD)
                          || (req_op == `LCPSC_OP_LDRES);
                  done    <= 1'b1;
                end else begin
                  mss_req <= (req_op == `LCPSC_OP_TOUCH)   ? `LCPSC_RQ_TOUCH :
                             (req_op == `LCPSC_OP_TOUCHST) ? `LCPSC_RQ_STOUCH :
                             (req_op == `LCPSC_OP_LDRES)   ? `LCPSC_RQ_RESLOAD :
                                                             `LCPSC_RQ_LOAD;
                  mss_valid <= 1'b1;
                  state     <= ST_WAIT;
                  busy      <= 1'b1;
                end
              end
              `LCPSC_OP_STORE, `LCPSC_OP_STCOND: begin
                if (req_op == `LCPSC_OP_STCOND && !reservation) begin
                  done <= 1'b1;
                end else if (inh || wt) begin
                  mss_req   <= (req_op == `LCPSC_OP_STCOND) ?
                               `LCPSC_RQ_STCOND : `LCPSC_RQ_STORE;
                  mss_valid <= 1'b1;
                  state     <= ST_WAIT;
                  busy      <= 1'b1;
                end else if (req_hit && (cur_st != `LCPSC_ST_S || !coh)) begin
                  s_wr  <= 1'b1;
                  s_idx <= cur_idx;
                  s_val <= `LCPSC_ST_M;
                  if (req_op == `LCPSC_OP_STCOND) begin
                    stcond_ok   <= 1'b1;
                    reservation <= 1'b0;
                  end
                  done <= 1'b1;
                end else begin
                  if (req_hit) begin
                    s_wr  <= 1'b1;                 // Shared hit re-allocates
                    s_idx <= cur_idx;
                    s_val <= `LCPSC_ST_I;
                  end
                  mss_req   <= (req_op == `LCPSC_OP_STCOND) ?
                               `LCPSC_RQ_STCOND : `LCPSC_RQ_STORE;
                  mss_valid <= 1'b1;
                  state     <= ST_WAIT;
                  busy      <= 1'b1;
                end
              end
              `LCPSC_OP_STOP: begin
                stream_active[req_stream] <= 1'b0;
                done <= 1'b1;
              end
              `LCPSC_OP_BSTORE, `LCPSC_OP_BFLUSH: begin
                mss_req <= (req_hit && cur_st == `LCPSC_ST_M) ?
                           ((req_op == `LCPSC_OP_BFLUSH) ? `LCPSC_RQ_CASTOUT
                                                         : `LCPSC_RQ_CLEAN) :
                           ((req_op == `LCPSC_OP_BFLUSH) ? `LCPSC_RQ_BFLUSH
                                                         : `LCPSC_RQ_BSTORE);
                if (req_hit && cur_st == `LCPSC_ST_M && req_op == `LCPSC_OP_BFLUSH)
                  mss_attr[`LCPSC_ATTR_W] <= 1'b1; // Flush castout is write-through
                mss_valid <= 1'b1;
                if (req_hit) begin
                  s_wr  <= 1'b1;
                  s_idx <= cur_idx;
                  s_val <= `LCPSC_ST_I;
                end
                done <= 1'b1;
              end
              `LCPSC_OP_BZERO: begin
                if (inh || wt) begin
                  done <= 1'b1;
                end else if (req_hit && (cur_st != `LCPSC_ST_S || !coh)) begin
                  s_wr      <= 1'b1;
                  s_idx     <= cur_idx;
                  s_val     <= `LCPSC_ST_M;
                  zero_line <= 1'b1;
                  done      <= 1'b1;
                end else begin
                  mss_req   <= `LCPSC_RQ_BZERO;
                  mss_valid <= 1'b1;
                  state     <= ST_WAIT;
                  busy      <= 1'b1;
                end
              end
              default: done <= 1'b1;
            endcase
            if (req_op == `LCPSC_OP_TOUCH || req_op == `LCPSC_OP_TOUCHST)
              stream_active[req_stream] <= 1'b1;
          end
        end
        ST_WAIT: begin
          if (rsp_valid) got_excl <= rsp_excl;     // Response is gone by reload
          if (rsp_valid && rsp_crit && !fetch &&
              (op == `LCPSC_OP_LOAD || op == `LCPSC_OP_LDRES))
            fwd_crit <= 1'b1;
          if ((rsp_valid && rsp_last) || op == `LCPSC_OP_BZERO) begin
            if (attr[`LCPSC_ATTR_I] || (attr[`LCPSC_ATTR_W] && !fetch)) begin
              busy  <= 1'b0;
              done  <= 1'b1;
              state <= ST_IDLE;
            end else begin
              line_state <= vic_st;
              state      <= ST_CAST;
            end
          end
        end
        ST_CAST: begin
          // Data victim chosen now, at reload time; instruction victim kept from the miss
          mss_way <= fetch ? ic_victim : d_victim;
          if (!fetch && vic_st == `LCPSC_ST_M) begin
            mss_req   <= `LCPSC_RQ_CASTOUT;
            mss_attr  <= attr;
            mss_attr[`LCPSC_ATTR_W] <= 1'b0;
            mss_valid <= 1'b1;
          end
          if (!fetch) begin
            s_wr  <= 1'b1;
            s_idx <= vic_idx;
            s_val <= (op == `LCPSC_OP_BZERO || op == `LCPSC_OP_STORE
                      || op == `LCPSC_OP_STCOND) ? `LCPSC_ST_M :
                     (got_excl ? `LCPSC_ST_E : `LCPSC_ST_S);
            d_upd     <= 1'b1;
            d_upd_set <= set;
            d_upd_way <= d_victim;
            d_upd_inv <= vlru;
            zero_line <= (op == `LCPSC_OP_BZERO);
            if (op == `LCPSC_OP_STCOND) begin
              stcond_ok   <= 1'b1;
              reservation <= 1'b0;
            end
          end else begin
            i_upd     <= 1'b1;
            i_upd_set <= set;
            i_upd_way <= ic_victim;
          end
          busy  <= 1'b0;
          done  <= 1'b1;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // lcpsc_ctrl
`default_nettype wire

// ==== test/lcpsc_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "lcpsc_defines.vh"
module lcpsc_asserts (
  input wire logic       clock,
  input wire logic       srst,
  input wire logic       instr_flash_invalidate_bit,
  input wire logic       req_valid,
  input wire logic [3:0] req_op,
  input wire logic       req_hit,
  input wire logic       req_snoop,
  input wire logic [2:0] access_attribute_bits,
  input wire logic       rsp_valid,
  input wire logic       rsp_crit,
  input wire logic       busy,
  input wire logic       mss_valid,
  input wire logic [3:0] mss_req,
  input wire logic [2:0] mss_attr,
  input wire logic       fwd_crit,
  input wire logic       fwd_hit,
  input wire logic       done,
  input wire logic       reservation,
  input wire logic       zero_line,
  input wire logic [2:0] ic_victim
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  logic       take;
  logic [3:0] op;
  logic [2:0] attr;
  logic       clean;
  logic       clean_miss;
  assign take = req_valid && !busy;
  // Operation in flight, and whether the icache tree is fresh from a flash
  always_ff @(posedge clock) begin
    if (srst) begin
      op         <= 4'h0;
      attr       <= 3'h0;
      clean      <= 1'b0;
      clean_miss <= 1'b0;
    end else begin
      if (instr_flash_invalidate_bit)
        clean <= 1'b1;
      else if (take && req_op == `LCPSC_OP_FETCH && !req_snoop)
        clean <= 1'b0;
      if (take) begin
        op         <= req_op;
        attr       <= access_attribute_bits;
        clean_miss <= clean && !req_hit && !req_snoop;
      end
    end
  end
  chk_load_miss_req: assert property (
    take && req_op == `LCPSC_OP_LOAD && !req_hit && !access_attribute_bits[1]
    |=> mss_valid && mss_req == `LCPSC_RQ_LOAD) else $error("load miss sent no load request");
  chk_load_hit_quiet: assert property (
    take && req_op == `LCPSC_OP_LOAD && req_hit && !access_attribute_bits[1]
    |=> done && !mss_valid) else $error("load hit not answered locally");
  chk_attr_pass: assert property (
    mss_valid && mss_req inside {`LCPSC_RQ_LOAD, `LCPSC_RQ_TOUCH, `LCPSC_RQ_RESLOAD}
    |-> mss_attr == attr) else $error("request attributes altered");
  chk_inhib_bypass: assert property (
    take && req_op == `LCPSC_OP_LOAD && access_attribute_bits[1]
    |=> mss_valid && mss_req == `LCPSC_RQ_LOAD && mss_attr[1]) else $error("inhibited load lost");
  chk_crit_fwd: assert property (
    busy && rsp_valid && rsp_crit && op == `LCPSC_OP_LOAD |-> ##[1:2] fwd_crit)
    else $error("critical beat not forwarded");
  chk_no_forward: assert property (
    op inside {`LCPSC_OP_STORE, `LCPSC_OP_TOUCH, `LCPSC_OP_TOUCHST} |-> !fwd_crit && !fwd_hit)
    else $error("store or touch forwarded data");
  chk_stop_quiet: assert property (
    take && req_op == `LCPSC_OP_STOP |=> !mss_valid [*3]) else $error("stream stop sent a request");
  chk_stcond_gate: assert property (
    take && req_op == `LCPSC_OP_STCOND && !reservation |=> !mss_valid ##1 !mss_valid)
    else $error("conditional store ran without reservation");
  chk_resv_set: assert property (
    done && op == `LCPSC_OP_LDRES |-> ##[0:1] reservation) else $error("reservation not set");
  chk_bzero_fill: assert property (
    take && req_op == `LCPSC_OP_BZERO && access_attribute_bits[2:1] == 2'b00
    |-> ##[1:8] zero_line) else $error("block zero did not fill");
  chk_flash_way0: assert property (
    done && op == `LCPSC_OP_FETCH && clean_miss |-> ic_victim == 3'h0)
    else $error("victim after flash not way zero");
  cover property (take && req_op == `LCPSC_OP_LOAD && !req_hit);
  cover property (fwd_crit);
  cover property (zero_line);
endmodule // lcpsc_asserts
bind lcpsc_ctrl lcpsc_asserts u_chk (
  .clock, .srst, .instr_flash_invalidate_bit, .req_valid, .req_op, .req_hit, .req_snoop,
  .access_attribute_bits, .rsp_valid, .rsp_crit, .busy, .mss_valid, .mss_req, .mss_attr,
  .fwd_crit, .fwd_hit, .done, .reservation, .zero_line, .ic_victim
);
`default_nettype wire

// ==== test/lcpsc_mss_model.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "lcpsc_defines.vh"
module lcpsc_mss_model (
  input  wire logic       clock,
  input  wire logic       slow,
  input  wire logic       excl,
  input  wire logic       mss_valid,
  input  wire logic [3:0] mss_req,
  output var  logic       rsp_valid = 1'b0,
  output var  logic       rsp_excl = 1'b0,
  output var  logic       rsp_crit = 1'b0,
  output var  logic       rsp_last = 1'b0
);
  // Reloads get a critical beat, then a last beat
  always @(posedge clock) begin
    if (mss_valid && mss_req inside {`LCPSC_RQ_LOAD, `LCPSC_RQ_TOUCH, `LCPSC_RQ_STOUCH,
        `LCPSC_RQ_RESLOAD, `LCPSC_RQ_STCOND, `LCPSC_RQ_FETCH, `LCPSC_RQ_STORE}) begin
      repeat (slow ? 6 : 1) @(posedge clock);
      rsp_valid <= 1'b1;
      rsp_excl  <= excl;
      rsp_crit  <= 1'b1;
      rsp_last  <= 1'b0;
      @(posedge clock);
      rsp_crit  <= 1'b0;
      rsp_last  <= 1'b1;
      @(posedge clock);
      // Released qualifiers show the inverse of their last value
      rsp_valid <= 1'b0;
      rsp_excl  <= !excl;
      rsp_crit  <= 1'b1;
      rsp_last  <= 1'b0;
    end
  end
endmodule // lcpsc_mss_model
`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "lcpsc_defines.vh"
module testbench;
  logic clock, srst = 1'b1, data_flash_invalidate_bit = 1'b0, instr_flash_invalidate_bit = 1'b0;
  logic req_valid = 1'b0, req_hit = 1'b0, req_vlru = 1'b0, req_snoop = 1'b0, slow = 1'b0;
  logic [3:0] req_op = 4'h0, req_stream = 4'h0, mss_req;
  logic [6:0] req_set = 7'h05, tree;
  logic [2:0] req_way = 3'h0, access_attribute_bits = 3'h0, mss_attr, ic_victim, exp_way;
  logic excl = 1'b1, rsp_valid, rsp_excl, rsp_crit, rsp_last, busy, mss_valid, fwd_crit;
  logic fwd_hit, done, reservation, stcond_ok, zero_line, seen_req, seen_fwd, seen_hit;
  logic seen_zero;
  logic [3:0] last_req;
  logic [2:0] last_attr, mss_way;
  logic [15:0] stream_active;
  int n_mismatch = 0, check_count = 0;
  lcpsc_ctrl dut (.clock, .srst, .data_flash_invalidate_bit, .instr_flash_invalidate_bit,
    .req_valid, .req_op, .req_set, .req_way, .req_hit, .req_vlru, .req_snoop,
    .access_attribute_bits, .req_stream, .rsp_valid, .rsp_excl, .rsp_crit, .rsp_last, .busy,
    .mss_valid, .mss_req, .mss_attr, .mss_set(), .mss_way, .fwd_crit, .fwd_hit, .done,
    .reservation, .stcond_ok, .stream_active, .zero_line, .ic_victim, .line_state());
  lcpsc_mss_model u_mss (.clock, .slow, .excl, .mss_valid, .mss_req, .rsp_valid, .rsp_excl,
    .rsp_crit, .rsp_last);
  // Core clock, 100 ns period
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Victim by walking the tree from the root
  function automatic logic [2:0] walk(input logic [6:0] t);
    if (!t[0])
      return t[1] ? {2'b01, t[4]} : {2'b00, t[3]};
    return t[2] ? {2'b11, t[6]} : {2'b10, t[5]};
  endfunction
  // Most-recent update of three tree bits
  function automatic logic [6:0] mark(input logic [6:0] t, input logic [2:0] w);
    t[0] = !w[2];
    t[w[2] ? 2 : 1] = !w[1];
    t[3 + w[2:1]] = !w[0];
    return t;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // One request, held for the accepting edge, then watched until done
  task automatic run_op(input logic [3:0] op, input logic hit, input logic [2:0] way,
                        input logic [2:0] attr);
    int n;
    @(posedge clock);
    req_valid <= 1'b1;
    req_op <= op;
    req_hit <= hit;
    req_way <= way;
    access_attribute_bits <= attr;
    @(posedge clock);
    req_valid <= 1'b0;
    {seen_req, seen_fwd, seen_hit, seen_zero} = 4'h0;
    for (n = 0; n < 300 && done !== 1'b1; n++) begin
      @(posedge clock);
      if (mss_valid === 1'b1) begin
        seen_req = 1'b1;
        last_req = mss_req;
        last_attr = mss_attr;
      end
      seen_fwd |= (fwd_crit === 1'b1);
      seen_hit |= (fwd_hit === 1'b1);
      seen_zero |= (zero_line === 1'b1);
    end
    chk(done, 1'b1);
    @(posedge clock);
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    test_done;
  end
  initial begin
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    chk({busy, mss_valid, done, reservation, stcond_ok, zero_line}, 16'h0);
    chk(stream_active, 16'h0);
    data_flash_invalidate_bit <= 1'b1;
    instr_flash_invalidate_bit <= 1'b1;
    @(posedge clock);
    data_flash_invalidate_bit <= 1'b0;
    instr_flash_invalidate_bit <= 1'b0;
    tree = 7'h00;
    // Eight icache misses walk every way from the cleared tree
    for (int i = 0; i < 8; i++) begin
      req_set <= 7'h11;
      exp_way = walk(tree);
      run_op(`LCPSC_OP_FETCH, 1'b0, 3'h0, 3'h0);
      chk(ic_victim, exp_way);
      chk(last_req, `LCPSC_RQ_FETCH);
      tree = mark(tree, exp_way);
    end
    run_op(`LCPSC_OP_FETCH, 1'b1, 3'h3, 3'h0);
    tree = mark(tree, 3'h3);
    req_snoop <= 1'b1;
    run_op(`LCPSC_OP_FETCH, 1'b1, 3'h6, 3'h0);
    req_snoop <= 1'b0;
    req_vlru <= 1'b1;
    run_op(`LCPSC_OP_FETCH, 1'b0, 3'h0, 3'h0);
    chk(ic_victim, walk(tree));
    req_vlru <= 1'b0;
    // Cacheable load miss with a slow answer, then a hit on the same line
    req_set <= 7'h05;
    slow <= 1'b1;
    run_op(`LCPSC_OP_LOAD, 1'b0, 3'h0, 3'h1);
    chk({seen_req, last_req, last_attr}, {1'b1, `LCPSC_RQ_LOAD, 3'h1});
    chk(seen_fwd, 1'b1);
    run_op(`LCPSC_OP_LOAD, 1'b1, 3'h0, 3'h1);
    chk({seen_req, seen_hit}, 2'b01);
    slow <= 1'b0;
    run_op(`LCPSC_OP_LOAD, 1'b0, 3'h0, 3'h2);
    chk({last_req, last_attr}, {`LCPSC_RQ_LOAD, 3'h2});
    run_op(`LCPSC_OP_STORE, 1'b1, 3'h0, 3'h0);
    chk({seen_fwd, seen_hit}, 2'b00);
    // Touch on a stream, then stop that stream
    req_set <= 7'h09;
    req_stream <= 4'h5;
    run_op(`LCPSC_OP_TOUCH, 1'b0, 3'h0, 3'h1);
    chk({seen_fwd, seen_hit, last_req}, {2'b00, `LCPSC_RQ_TOUCH});
    chk(stream_active[5], 1'b1);
    run_op(`LCPSC_OP_STOP, 1'b0, 3'h0, 3'h1);
    chk({seen_req, stream_active[5]}, 2'b00);
    // Reservation set, consumed, then a refused conditional store
    excl <= 1'b0;
    req_set <= 7'h0a;
    run_op(`LCPSC_OP_LDRES, 1'b0, 3'h0, 3'h0);
    chk({last_req, reservation}, {`LCPSC_RQ_RESLOAD, 1'b1});
    excl <= 1'b1;
    run_op(`LCPSC_OP_STCOND, 1'b0, 3'h0, 3'h0);
    chk({last_req, reservation, stcond_ok}, {`LCPSC_RQ_STCOND, 2'b01});
    run_op(`LCPSC_OP_STCOND, 1'b0, 3'h0, 3'h0);
    chk(seen_req, 1'b0);
    // Block zero a fresh line, then flush it twice
    req_set <= 7'h06;
    run_op(`LCPSC_OP_BZERO, 1'b0, 3'h0, 3'h0);
    chk(seen_zero, 1'b1);
    run_op(`LCPSC_OP_BFLUSH, 1'b1, 3'h0, 3'h0);
    chk({last_req, last_attr[2]}, {`LCPSC_RQ_CASTOUT, 1'b1});
    run_op(`LCPSC_OP_BFLUSH, 1'b1, 3'h0, 3'h0);
    chk(last_req, `LCPSC_RQ_BFLUSH);
    // Fill a set, age way five, flush all
    req_set <= 7'h07;
    for (int i = 0; i < 8; i++)
      run_op(`LCPSC_OP_BZERO, 1'b0, 3'h0, 3'h0);
    req_vlru <= 1'b1;
    run_op(`LCPSC_OP_LOAD, 1'b1, 3'h5, 3'h0);
    req_vlru <= 1'b0;
    run_op(`LCPSC_OP_BZERO, 1'b0, 3'h0, 3'h0);
    chk({last_req, mss_way}, {`LCPSC_RQ_CASTOUT, 3'h5});
    for (int i = 0; i < 8; i++) begin
      run_op(`LCPSC_OP_LOAD, 1'b1, i[2:0], 3'h0);
      run_op(`LCPSC_OP_BFLUSH, 1'b1, i[2:0], 3'h0);
      chk(last_req, `LCPSC_RQ_CASTOUT);
    end
    test_done;
  end
endmodule // testbench
`default_nettype wire
